// [rtl/sfbp_defines.vh]
/*
 holds the opcodes, address field layout and timing counts of the buffered
 program sequencer; assumes a 250 MHz core clock.
*/
`ifndef SFBP_DEFINES_VH
`define SFBP_DEFINES_VH

// ==========================================
// opcodes
`define SFBP_OP_PROG_NE_B1  8'h88
`define SFBP_OP_PROG_NE_B2  8'h89
`define SFBP_OP_PTB_B1      8'h82
`define SFBP_OP_PTB_B2      8'h85
`define SFBP_OP_BYTE_PROG   8'h02
`define SFBP_OP_RMW_B1      8'h58
`define SFBP_OP_RMW_B2      8'h59

// ==========================================
// page sizes and address layout
`define SFBP_PAGE_264       9'h108
`define SFBP_PAGE_256       9'h100
`define SFBP_PAGE_MSB_264   19
`define SFBP_PAGE_MSB_256   18

// ==========================================
// timing, in ns, and derived cycle counts at 4 ns
`define SFBP_CLK_NS         4
`define SFBP_T_BYTE_NS      8000
`define SFBP_T_PAGE_NS      3000000
`define SFBP_T_EP_NS        25000000
`define SFBP_T_XFER_NS      400000
`define SFBP_BYTE_CYC       (`SFBP_T_BYTE_NS / `SFBP_CLK_NS)
`define SFBP_PAGE_CYC       (`SFBP_T_PAGE_NS / `SFBP_CLK_NS)
`define SFBP_EP_CYC         (`SFBP_T_EP_NS / `SFBP_CLK_NS)
`define SFBP_XFER_CYC       (`SFBP_T_XFER_NS / `SFBP_CLK_NS)

`endif

// [rtl/sfbp_sync.v]
/*
 two flip-flop synchroniser for one pin level.
 assumes the pin is asynchronous to i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module sfbp_sync #(
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input  wire i_clk,
   input  wire i_rst,
   input  wire i_ce,
   // pin and synced level
   input  wire i_pin,
   output reg  o_lvl
);
   reg meta_reg;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= RST_VAL;
         o_lvl    <= RST_VAL;
      end else if (i_ce) begin
         meta_reg <= i_pin;
         o_lvl    <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// [rtl/sfbp_buffer.v]
/*
 one sram data buffer with a single write port and a combinational read port.
 assumes one write per cycle at most.
*/
`timescale 1ns/10ps
`default_nettype none
module sfbp_buffer #(
   parameter DEPTH = 264,
   parameter AW    = 9
) (
   // clock
   input  wire          i_clk,
   input  wire          i_ce,
   // write port
   input  wire          i_we,
   input  wire [AW-1:0] i_waddr,
   input  wire [7:0]    i_wdata,
   // read port
   input  wire [AW-1:0] i_raddr,
   output wire [7:0]    o_rdata
);
   reg [7:0] mem [0:DEPTH-1];

   always @(posedge i_clk) begin
      if (i_ce && i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   assign o_rdata = mem[i_raddr];
endmodule
`default_nettype wire

// [rtl/sfbp_core.v]
/*
 buffered program command sequencer: decodes the serial command, loads the
 buffers, and runs the self-timed array operation while reporting busy and the
 erase/program error flag.
 assumes the array engine outside answers i_arr_fail for the operation and
 that the serial pins are asynchronous to i_clk (link clock sampled here).
*/
// Contract
// - 264 mode program-no-erase: 88h/89h, 4 dummy, 11 page, 9 dummy bits.
// - 256 mode program-no-erase: same opcodes, 3 dummy, page in A18-A8, 8 dummy; the core takes 5 dummy bits (A23-A19).
// - cs rise after 88h/89h copies buffer to page, busy until done.
// - every erased or programmed byte verified; failure sets error flag.
// - 82h/85h program-through-buffer; 264 mode has page and 9-bit offset.
// - 256 mode program-through-buffer: page bits 18-8, 8-bit offset.
// - data bytes stored in buffer at rising offsets, wrapping to zero.
// - cs rise after 82h/85h erases page then programs, busy throughout.
// - 02h loads buffer one; 264 mode 9-bit offset, 1 to 264 bytes.
// - 256 mode 02h: 8-bit offset, 1 to 256 bytes, wrapping.
// - byte program writes only received bytes, rest of page unchanged.
// - cs rise mid-byte aborts byte program and read-modify-write.
// - byte program time is byte time times count, capped at page time.
// - 256 mode page and offset form one 19-bit linear address.
// - 58h/59h read-modify-write; 264 mode page and 9-bit byte offset.
// - 256 mode read-modify-write: page bits 18-8, offset bits 7-0.
// - read-modify-write takes up to a page of bytes, wrap, changes only those.
// - rmw fetches page to buffer, merges, erases and reprograms from buffer.
// - rmw self-timed within program time, busy shown, failures flagged.
// - rmw with no data bytes performs automatic page rewrite.
`timescale 1ns/10ps
`default_nettype none
`include "sfbp_defines.vh"
module sfbp_core #(
   parameter BYTE_CYC = `SFBP_BYTE_CYC,
   parameter PAGE_CYC = `SFBP_PAGE_CYC,
   parameter EP_CYC   = `SFBP_EP_CYC,
   parameter XFER_CYC = `SFBP_XFER_CYC
) (
   // clock, reset, enable
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_ce,
   // serial link pins
   input  wire        i_cs_n,
   input  wire        i_sck,
   input  wire        i_si,
   // configuration and array engine
   input  wire        i_page_256,
   input  wire        i_arr_fail,
   // status and array operation
   output reg         o_busy,
   output reg         o_erase_program_error_flag,
   output reg  [2:0]  o_op_kind,
   output reg  [18:0] o_linear_array_address,
   output reg  [10:0] o_page_number_bits,
   output reg         o_buf_sel,
   output reg  [8:0]  o_prog_count,
   output reg         o_buf_we,
   output reg  [8:0]  o_buf_addr,
   output reg  [7:0]  o_buf_data
);
   // op kinds shown to the array engine
   localparam [2:0] K_NONE = 3'h0, K_PROG = 3'h1, K_EP = 3'h2, K_BYTE = 3'h3;
   localparam [2:0] K_RMW = 3'h4, K_REWRITE = 3'h5;
   // sequencer states
   localparam [1:0] S_IDLE = 2'h0, S_CMD = 2'h1, S_RUN = 2'h2;

   // ==========================================
   // pin synchronisers
   wire cs_n_s, sck_s, si_s;
   sfbp_sync #(.RST_VAL(1'b1)) u_cs (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_pin(i_cs_n), .o_lvl(cs_n_s));
   sfbp_sync #(.RST_VAL(1'b0)) u_ck (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_pin(i_sck), .o_lvl(sck_s));
   sfbp_sync #(.RST_VAL(1'b0)) u_si (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_pin(i_si), .o_lvl(si_s));

   reg        sck_d_reg, cs_d_reg;
   wire       sck_rise = sck_s & ~sck_d_reg;
   wire       cs_rise  = cs_n_s & ~cs_d_reg;
   wire       cs_fall  = ~cs_n_s & cs_d_reg;

   // ==========================================
   // buffers
   wire [7:0] rd1, rd2;
   reg        we_reg;
   reg        wsel_reg;
   reg  [8:0] waddr_reg;
   reg  [7:0] wdata_reg;
   // read address is the stream pointer so data and address leave in the same cycle
   reg  [8:0] rd_ptr_reg;
   sfbp_buffer #(.DEPTH(264), .AW(9)) u_buf1 (.i_clk(i_clk), .i_ce(i_ce), .i_we(we_reg & ~wsel_reg),
      .i_waddr(waddr_reg), .i_wdata(wdata_reg), .i_raddr(rd_ptr_reg), .o_rdata(rd1));
   sfbp_buffer #(.DEPTH(264), .AW(9)) u_buf2 (.i_clk(i_clk), .i_ce(i_ce), .i_we(we_reg & wsel_reg),
      .i_waddr(waddr_reg), .i_wdata(wdata_reg), .i_raddr(rd_ptr_reg), .o_rdata(rd2));

   // ==========================================
   // command shifter and sequencer
   reg [1:0]  state_reg;
   reg [2:0]  bit_reg;
   reg [7:0]  shift_reg;
   reg [2:0]  byte_idx_reg;
   reg [7:0]  op_reg;
   reg [23:0] addr_reg;
   reg [8:0]  ptr_reg;
   reg [8:0]  count_reg;
   reg [31:0] timer_reg;

   wire [7:0] byte_in  = {shift_reg[6:0], si_s};
   wire [8:0] page_sz  = i_page_256 ? `SFBP_PAGE_256 : `SFBP_PAGE_264;
   wire [8:0] ptr_inc  = (ptr_reg + 9'h001 == page_sz) ? 9'h000 : ptr_reg + 9'h001;
   wire [8:0] rd_inc   = (rd_ptr_reg + 9'h001 == page_sz) ? 9'h000 : rd_ptr_reg + 9'h001;
   wire       has_data = (op_reg == `SFBP_OP_PTB_B1) || (op_reg == `SFBP_OP_PTB_B2) ||
                         (op_reg == `SFBP_OP_BYTE_PROG) || (op_reg == `SFBP_OP_RMW_B1) ||
                         (op_reg == `SFBP_OP_RMW_B2);
   // full opcode compare picks buffer two for 89h, 85h, 59h
   wire       op_sel2  = (op_reg == `SFBP_OP_PROG_NE_B2) || (op_reg == `SFBP_OP_PTB_B2) ||
                         (op_reg == `SFBP_OP_RMW_B2);
   wire [10:0] pg_264  = addr_reg[19:9];
   wire [8:0]  off_264 = addr_reg[8:0];
   wire [10:0] pg_256  = addr_reg[18:8];
   wire [8:0]  off_256 = {1'b0, addr_reg[7:0]};
   wire [10:0] pg_sel  = i_page_256 ? pg_256 : pg_264;
   wire [8:0]  off_sel = i_page_256 ? off_256 : off_264;
   wire [31:0] byte_time = BYTE_CYC * {23'h000000, count_reg};
   wire [31:0] prog_time = (byte_time > PAGE_CYC) ? PAGE_CYC : byte_time;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg                  <= S_IDLE;
         sck_d_reg                  <= 1'b0;
         cs_d_reg                   <= 1'b1;
         bit_reg                    <= 3'h0;
         shift_reg                  <= 8'h00;
         byte_idx_reg               <= 3'h0;
         op_reg                     <= 8'h00;
         addr_reg                   <= 24'h000000;
         ptr_reg                    <= 9'h000;
         count_reg                  <= 9'h000;
         timer_reg                  <= 32'h00000000;
         rd_ptr_reg                 <= 9'h000;
         we_reg                     <= 1'b0;
         wsel_reg                   <= 1'b0;
         waddr_reg                  <= 9'h000;
         wdata_reg                  <= 8'h00;
         o_busy                     <= 1'b0;
         o_erase_program_error_flag <= 1'b0;
         o_op_kind                  <= K_NONE;
         o_linear_array_address     <= 19'h00000;
         o_page_number_bits         <= 11'h000;
         o_buf_sel                  <= 1'b0;
         o_prog_count               <= 9'h000;
         o_buf_we                   <= 1'b0;
         o_buf_addr                 <= 9'h000;
         o_buf_data                 <= 8'h00;
      end else if (i_ce) begin
         sck_d_reg <= sck_s;
         cs_d_reg  <= cs_n_s;
         we_reg    <= 1'b0;
         o_buf_we  <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (cs_fall) begin
                  state_reg    <= S_CMD;
                  bit_reg      <= 3'h0;
                  byte_idx_reg <= 3'h0;
                  count_reg    <= 9'h000;
               end
            end
            S_CMD: begin
               if (!cs_n_s && sck_rise) begin
                  shift_reg <= byte_in;
                  bit_reg   <= bit_reg + 3'h1;
                  if (bit_reg == 3'h7) begin
                     if (byte_idx_reg == 3'h0) begin
                        op_reg       <= byte_in;
                        byte_idx_reg <= 3'h1;
                     end else if (byte_idx_reg != 3'h4) begin
                        addr_reg     <= {addr_reg[15:0], byte_in};
                        byte_idx_reg <= byte_idx_reg + 3'h1;
                        if (byte_idx_reg == 3'h3) begin
                           ptr_reg <= i_page_256 ? {1'b0, byte_in} : {addr_reg[0], byte_in};
                        end
                     end else if (has_data) begin
                        we_reg    <= 1'b1;
                        wsel_reg  <= op_sel2;
                        waddr_reg <= ptr_reg;
                        wdata_reg <= byte_in;
                        ptr_reg   <= ptr_inc;
                        if (count_reg != page_sz) begin
                           count_reg <= count_reg + 9'h001;
                        end
                     end
                  end
               end
               if (cs_rise) begin
                  state_reg <= S_IDLE;
                  if (byte_idx_reg == 3'h4 && (bit_reg == 3'h0 ||
                      !((op_reg == `SFBP_OP_BYTE_PROG) || (op_reg == `SFBP_OP_RMW_B1) ||
                        (op_reg == `SFBP_OP_RMW_B2)))) begin
                     o_linear_array_address <= i_page_256 ? {pg_256, off_256[7:0]} : {pg_264, off_264[7:0]};
                     o_page_number_bits     <= pg_sel;
                     o_buf_sel              <= op_sel2;
                     o_prog_count           <= count_reg;
                     o_busy                 <= 1'b1;
                     o_erase_program_error_flag <= 1'b0;
                     state_reg              <= S_RUN;
                     rd_ptr_reg             <= 9'h000;
                     case (op_reg)
                        `SFBP_OP_PROG_NE_B1, `SFBP_OP_PROG_NE_B2: begin
                           o_op_kind <= K_PROG;
                           timer_reg <= PAGE_CYC;
                           count_reg <= page_sz;
                        end
                        `SFBP_OP_PTB_B1, `SFBP_OP_PTB_B2: begin
                           o_op_kind <= K_EP;
                           timer_reg <= EP_CYC;
                           count_reg <= page_sz;
                        end
                        `SFBP_OP_BYTE_PROG: begin
                           o_op_kind <= K_BYTE;
                           timer_reg <= (prog_time == 32'h0) ? 32'h1 : prog_time;
                           rd_ptr_reg <= off_sel;
                        end
                        `SFBP_OP_RMW_B1, `SFBP_OP_RMW_B2: begin
                           o_op_kind  <= (count_reg == 9'h000) ? K_REWRITE : K_RMW;
                           timer_reg  <= PAGE_CYC;
                           count_reg  <= page_sz;
                        end
                        default: begin
                           o_busy    <= 1'b0;
                           state_reg <= S_IDLE;
                        end
                     endcase
                  end
               end
            end
            S_RUN: begin
               // stream only received bytes for byte program, the whole page otherwise
               if (count_reg != 9'h000) begin
                  o_buf_we   <= 1'b1;
                  o_buf_addr <= rd_ptr_reg;
                  o_buf_data <= o_buf_sel ? rd2 : rd1;
                  rd_ptr_reg <= rd_inc;
                  count_reg  <= count_reg - 9'h001;
               end
               if (i_arr_fail) begin
                  o_erase_program_error_flag <= 1'b1;
               end
               // busy holds until timer and stream are both done, so no byte leaks out while idle
               if (timer_reg > 32'h1) begin
                  timer_reg <= timer_reg - 32'h1;
               end else if (count_reg == 9'h000) begin
                  o_busy    <= 1'b0;
                  o_op_kind <= K_NONE;
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [tb/sfbp_core_chk.sv]
/* assertions on the ports of the buffered program sequencer.
   assumes one clock domain, reset asynchronous and active high. */
`timescale 1ns/10ps
`default_nettype none
module sfbp_core_chk #(
   parameter BYTE_CYC = 4,
   parameter PAGE_CYC = 200,
   parameter EP_CYC   = 300,
   parameter XFER_CYC = 10
) (
   // clock, reset and pins
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_cs_n,
   input wire logic        i_page_256,
   input wire logic        i_arr_fail,
   // status and buffer stream
   input wire logic        o_busy,
   input wire logic        o_erase_program_error_flag,
   input wire logic [2:0]  o_op_kind,
   input wire logic [18:0] o_linear_array_address,
   input wire logic [10:0] o_page_number_bits,
   input wire logic        o_buf_sel,
   input wire logic        o_buf_we,
   input wire logic [8:0]  o_buf_addr
);
   // ====================
   // run length counter: limit is fetch plus erase-program plus page program plus margin, above the longest run
   localparam int LIM = XFER_CYC + EP_CYC + PAGE_CYC + 8;
   logic [31:0] run_cnt;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         run_cnt <= 32'h00000000;
      end else begin
         run_cnt <= o_busy ? run_cnt + 32'h00000001 : 32'h00000000;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ====================
   // properties
   property p_start; $rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2); endproperty
   a_start: assert property (p_start) else $error("busy rose while selected");
   property p_len; run_cnt <= LIM; endproperty
   a_len: assert property (p_len) else $error("busy ran too long");
   property p_min; $rose(o_busy) |-> o_busy [*3]; endproperty
   a_min: assert property (p_min) else $error("busy pulse too short");
   property p_kind; o_busy |-> o_op_kind != 3'h0 && o_op_kind <= 3'h5; endproperty
   a_kind: assert property (p_kind) else $error("bad operation kind");
   property p_hold; o_busy && $past(o_busy) |-> $stable(o_op_kind) && $stable(o_page_number_bits); endproperty
   a_hold: assert property (p_hold) else $error("operation changed mid run");
   property p_quiet; o_buf_we |-> o_busy; endproperty
   a_quiet: assert property (p_quiet) else $error("buffer stream while idle");
   property p_lin; o_busy && i_page_256 |-> o_linear_array_address[18:8] == o_page_number_bits; endproperty
   a_lin: assert property (p_lin) else $error("linear address page mismatch");
   property p_err; $rose(o_erase_program_error_flag) |-> $past(i_arr_fail) && $past(o_busy); endproperty
   a_err: assert property (p_err) else $error("error flag without failure");
   property p_sel; o_busy && o_op_kind == 3'h3 |-> !o_buf_sel; endproperty
   a_sel: assert property (p_sel) else $error("byte program not on buffer one");
   property p_waddr; o_buf_we |-> o_buf_addr < (i_page_256 ? 9'h100 : 9'h108); endproperty
   a_waddr: assert property (p_waddr) else $error("buffer address past page end");
endmodule
bind sfbp_core sfbp_core_chk #(.BYTE_CYC(BYTE_CYC), .PAGE_CYC(PAGE_CYC), .EP_CYC(EP_CYC), .XFER_CYC(XFER_CYC)) u_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_page_256(i_page_256), .i_arr_fail(i_arr_fail),
   .o_busy(o_busy), .o_erase_program_error_flag(o_erase_program_error_flag), .o_op_kind(o_op_kind),
   .o_linear_array_address(o_linear_array_address), .o_page_number_bits(o_page_number_bits),
   .o_buf_sel(o_buf_sel), .o_buf_we(o_buf_we), .o_buf_addr(o_buf_addr));
`default_nettype wire

// [tb/sfbp_host.sv]
/* host serial controller model: one command per chip select frame.
   assumes the bench calls frame() and supplies the core clock for pacing. */
`timescale 1ns/10ps
`default_nettype none
module sfbp_host (
   // pacing clock
   input  wire logic i_clk,
   // link pins
   output var logic  o_cs_n,
   output var logic  o_sck,
   output var logic  o_si
);
   logic [7:0] dat [0:263];
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_si   = 1'b0;
   end
   // ====================
   // one bit, 48 ns link period; sck idles low between frames
   task automatic put_bit(input logic b);
      o_si = b;
      repeat (6) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (6) @(negedge i_clk);
      o_sck = 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
   endtask
   task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int n, input int xb);
      o_cs_n = 1'b0;
      repeat (4) @(negedge i_clk);
      put_byte(op);
      for (int i = 2; i >= 0; i--) put_byte(adr[8*i +: 8]);
      for (int i = 0; i < n; i++) begin
         dat[i] = 8'($urandom);
         put_byte(dat[i]);
      end
      for (int i = 0; i < xb; i++) put_bit(1'($urandom));
      repeat (6) @(negedge i_clk);
      o_cs_n = 1'b1;
      // released line shows the inverse, not a held value
      o_si = ~o_si;
   endtask
endmodule
`default_nettype wire

// [tb/sfbp_core_tb.sv]
/* self-checking bench for the buffered program sequencer.
   assumes the host model drives the link; the array fail line is driven here. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("mismatch %s exp %h got %h", nm, e, a); end end
module sfbp_core_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        page_256 = 1'b0;
   logic        arr_fail = 1'b0;
   wire         cs_n, sck, si, busy, err_flag, buf_sel, buf_we;
   wire  [2:0]  op_kind;
   wire  [18:0] lin_addr;
   wire  [10:0] page_num;
   wire  [8:0]  prog_count, buf_addr;
   wire  [7:0]  buf_data;
   logic [7:0]  seen [0:263];
   logic [7:0]  ops [0:6] = '{8'h88, 8'h89, 8'h82, 8'h85, 8'h02, 8'h58, 8'h59};
   int          we_cnt = 0;
   int          ps = 264;
   int          error_cnt = 0;
   int          check_count = 0;
   always #2 clk = ~clk;
   sfbp_host host (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
   // page time above the 264-byte stream so the timer sets the busy length
   sfbp_core #(.BYTE_CYC(4), .PAGE_CYC(300), .EP_CYC(400), .XFER_CYC(10)) uut (
      .i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
      .i_page_256(page_256), .i_arr_fail(arr_fail), .o_busy(busy), .o_erase_program_error_flag(err_flag),
      .o_op_kind(op_kind), .o_linear_array_address(lin_addr), .o_page_number_bits(page_num),
      .o_buf_sel(buf_sel), .o_prog_count(prog_count), .o_buf_we(buf_we), .o_buf_addr(buf_addr),
      .o_buf_data(buf_data));
   always @(posedge clk) begin
      if (buf_we === 1'b1) begin
         seen[buf_addr] <= buf_data;
         we_cnt <= we_cnt + 1;
      end
   end
   // ====================
   // expectations and closing
   function automatic logic [2:0] exp_kind(input logic [7:0] op, input int n);
      case (op)
         8'h88, 8'h89: exp_kind = 3'h1;
         8'h82, 8'h85: exp_kind = 3'h2;
         8'h02:        exp_kind = 3'h3;
         default:      exp_kind = (n == 0) ? 3'h5 : 3'h4;
      endcase
   endfunction
   function automatic int exp_len(input logic [7:0] op, input int n);
      case (op)
         8'h88, 8'h89: exp_len = 300;
         8'h82, 8'h85: exp_len = 400;
         8'h02:        exp_len = (4 * n < 300) ? 4 * n : 300;
         default:      exp_len = 300;
      endcase
   endfunction
   task finish_test;
      if (error_cnt == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ====================
   // one command, run to completion and compared
   task automatic run_cmd(input logic [7:0] op, input logic [10:0] pg, input logic [8:0] off,
                          input int n, input int xb, input logic fail);
      int          len;
      int          el;
      logic [23:0] adr;
      el  = exp_len(op, n);
      adr = page_256 ? {5'h00, pg, off[7:0]} : {4'h0, pg, off};
      for (int i = 0; i < 264; i++) seen[i] = 8'hxx;
      we_cnt = 0;
      host.frame(op, adr, n, xb);
      arr_fail = fail;
      len = 0;
      while (busy !== 1'b1 && len < 20) begin
         @(negedge clk);
         len++;
      end
      if (xb != 0) begin
         `CHK("abort_busy", 1'b0, busy)
         return;
      end
      `CHK("busy_start", 1'b1, busy)
      if (busy !== 1'b1) finish_test();
      repeat (2) @(negedge clk);
      `CHK("op_kind", exp_kind(op, n), op_kind)
      `CHK("buf_sel", op[0], buf_sel)
      `CHK("page", pg, page_num)
      if (op[7:1] != 7'h44) begin
         `CHK("lin_addr", {pg, off[7:0]}, lin_addr)
         `CHK("count", n[8:0], prog_count)
      end
      len = 2;
      while (busy === 1'b1 && len < 2000) begin
         @(negedge clk);
         len++;
      end
      `CHK("busy_end", 1'b0, busy)
      if (busy !== 1'b0) finish_test();
      if (el != 0) `CHK("busy_len", 1'b1, (len + 2 >= el) && (len <= el + 2))
      `CHK("err_flag", fail, err_flag)
      arr_fail = 1'b0;
      for (int i = 0; i < n; i++) `CHK("buf_byte", host.dat[i], seen[(off + i) % ps])
      if (op == 8'h02) `CHK("we_cnt", n, we_cnt)
   endtask
   initial begin
      void'($urandom(32'h87fcdaf7));
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
      for (int m = 0; m < 2; m++) begin
         page_256 = m[0];
         ps = m ? 256 : 264;
         foreach (ops[k]) run_cmd(ops[k], 11'($urandom), 9'($urandom % ps),
                                  (ops[k][7:1] == 7'h44) ? 0 : 1 + $urandom % 8, 0, 1'b0);
         // wrap past the buffer end
         run_cmd(8'h02, 11'h7ff, 9'(ps - 2), 5, 0, 1'b0);
         run_cmd(8'h58, 11'h000, 9'(ps - 1), 3, 0, 1'b0);
         // no data bytes: page rewrite
         run_cmd(8'h59, 11'($urandom), 9'h000, 0, 0, 1'b0);
         // chip select raised mid-byte
         run_cmd(8'h02, 11'h123, 9'h010, 2, 3, 1'b0);
         run_cmd(8'h58, 11'h321, 9'h004, 1, 7, 1'b0);
         // verify failure, then cleared by the next run
         run_cmd(8'h85, 11'($urandom), 9'h000, 4, 0, 1'b1);
         run_cmd(8'h88, 11'($urandom), 9'h000, 0, 0, 1'b0);
      end
      // full page, beyond the page time cap
      run_cmd(8'h02, 11'h0aa, 9'h000, 256, 0, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
